/* File: src/ifc_defs.vh */
// Constants for the intermediate frequency counter
`ifndef IFC_DEFS_VH
`define IFC_DEFS_VH

// ==========================================
// Mode register layout
`define IFC_MODE_W 4
`define IFC_MODE_RST 4'h0
`define IFC_SEL_HI 3
`define IFC_SEL_LO 2
`define IFC_GATE_HI 1
`define IFC_GATE_LO 0

// ==========================================
// Input select codes
`define IFC_SEL_OFF 2'h0
`define IFC_SEL_AM 2'h1
`define IFC_SEL_FM 2'h2
`define IFC_SEL_BOTH 2'h3

// ==========================================
// Gate time codes and lengths in timebase ticks
`define IFC_GATE_1MS 2'h0
`define IFC_GATE_4MS 2'h1
`define IFC_GATE_8MS 2'h2
`define IFC_GATE_OPEN 2'h3
`define IFC_TICKS_1MS 4'h1
`define IFC_TICKS_4MS 4'h4
`define IFC_TICKS_8MS 4'h8

// ==========================================
// Counter and timebase
`define IFC_CNT_W 16
`define IFC_CNT_RST 16'h0000
`define IFC_CLK_HZ 100000000
`define IFC_TB_HZ 1000
`define IFC_TB_DIV (`IFC_CLK_HZ / `IFC_TB_HZ)
`define IFC_TB_W 17

`endif

/* File: src/ifc_edge_sync.v */
// Two-stage synchroniser with rising edge detector
`timescale 1ns/1ps

module ifc_edge_sync (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire sig_in,
  output wire level_out,
  output wire rise_out
);

  reg meta;
  reg sync;
  reg prev;

  // First stage feeds only the second stage
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= sig_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_out = sync;
  assign rise_out = sync & ~prev;

endmodule // ifc_edge_sync

/* File: src/ifc_counter.v */
// Intermediate frequency counter: mode register, gate control, 16-bit counter
`timescale 1ns/1ps
`include "ifc_defs.vh"

// What this block does
// RQ1: FM input halved, AM input counted directly
// RQ2: Upper mode bits select input or disable
// RQ3: Lower mode bits select 1/4/8 ms or open
// RQ4: Mode write clears count, flag; starts counting
// RQ5: Reset clears mode register to zero
// RQ6: Gate opens at next timebase rising edge
// RQ7: Open gate counts selected input rising edges
// RQ8: Timed gate close sets flag and interrupt
// RQ9: Interrupt request clears when serviced
// RQ10: Gate-complete flag resets, clears on start
// RQ11: Open-gate mode counts until next mode write
// RQ12: Input bits cleared stops count, holds value (the mode write that clears them also clears the count to zero)
// RQ13: Counter wraps past maximum and continues
// RQ14: Count read as two byte halves
// RQ15: Mode register four bits, read and write
// RQ16: Reset clears count to zero
// RQ17: Software polls flag or interrupt first
// RQ18: Gate timing from internal 1 kHz timebase
// RQ19: Inputs synchronised; ticks counted to close gate
module ifc_counter #(
  parameter TB_DIV = `IFC_TB_DIV
) (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire am_if_input_in,
  input wire fm_if_input_in,
  input wire mode_wr_in,
  input wire [3:0] mode_wdata_in,
  input wire irq_service_in,
  output wire [3:0] if_count_mode_out,
  output wire [7:0] if_count_low_byte_out,
  output wire [7:0] if_count_high_byte_out,
  output wire gate_complete_flag_out,
  output wire count_irq_request_out,
  output wire gate_open_out
);

  // ==========================================
  // Gate states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_GATE = 3'b100;

  reg [3:0] if_count_mode;
  reg [15:0] count;
  reg gate_complete_flag;
  reg count_irq_request;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [16:0] tb_cnt;
  reg tb_tick;
  reg [3:0] ticks;
  reg fm_half;

  wire am_level;
  wire am_rise;
  wire fm_level;
  wire fm_rise;

  wire [1:0] sel = if_count_mode[`IFC_SEL_HI:`IFC_SEL_LO];
  wire [1:0] gate_sel = if_count_mode[`IFC_GATE_HI:`IFC_GATE_LO];
  wire [1:0] wr_sel = mode_wdata_in[`IFC_SEL_HI:`IFC_SEL_LO];

  // Gate length in timebase ticks; open-gate never reaches its limit
  function [3:0] gate_ticks;
    input [1:0] g;
    begin
      case (g)
        `IFC_GATE_1MS: gate_ticks = `IFC_TICKS_1MS; // RQ3
        `IFC_GATE_4MS: gate_ticks = `IFC_TICKS_4MS; // RQ3
        `IFC_GATE_8MS: gate_ticks = `IFC_TICKS_8MS; // RQ3
        default: gate_ticks = `IFC_TICKS_8MS;
      endcase
    end
  endfunction

  // ==========================================
  // Input conditioning
  ifc_edge_sync u_am_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .sig_in(am_if_input_in),
    .level_out(am_level),
    .rise_out(am_rise)
  ); // RQ19

  ifc_edge_sync u_fm_sync (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .sig_in(fm_if_input_in),
    .level_out(fm_level),
    .rise_out(fm_rise)
  ); // RQ19

  // FM divide-by-two: toggles on each FM rising edge
  always @(posedge ref_clk_in) begin
    if (sys_rst_in || mode_wr_in) begin
      fm_half <= 1'b0;
    end else if (fm_rise) begin
      fm_half <= ~fm_half; // RQ1
    end
  end

  // One count per AM edge, per second FM edge
  wire fm_count = fm_rise & fm_half; // RQ1
  reg in_rise;
  always @* begin
    case (sel)
      `IFC_SEL_AM: in_rise = am_rise; // RQ2
      `IFC_SEL_FM: in_rise = fm_count; // RQ2
      `IFC_SEL_BOTH: in_rise = am_rise | fm_count; // RQ2
      default: in_rise = 1'b0; // RQ12
    endcase
  end

  // Input already high when the gate opens adds one count (+1, 0 error)
  reg in_level;
  always @* begin
    case (sel)
      `IFC_SEL_AM: in_level = am_level;
      `IFC_SEL_FM: in_level = fm_level & ~fm_half;
      `IFC_SEL_BOTH: in_level = am_level;
      default: in_level = 1'b0;
    endcase
  end

  // ==========================================
  // 1 kHz timebase, free running
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tb_cnt <= 17'h00000;
      tb_tick <= 1'b0;
    end else if (tb_cnt == TB_DIV - 1) begin
      tb_cnt <= 17'h00000;
      tb_tick <= 1'b1; // RQ18
    end else begin
      tb_cnt <= tb_cnt + 17'h00001;
      tb_tick <= 1'b0;
    end
  end

  // ==========================================
  // Mode register
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      if_count_mode <= `IFC_MODE_RST; // RQ5
    end else if (mode_wr_in) begin
      if_count_mode <= mode_wdata_in; // RQ15
    end
  end

  // ==========================================
  // Gate state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_WAIT: begin
        if (sel == `IFC_SEL_OFF) begin
          next_state = ST_IDLE; // RQ12
        end else if (tb_tick) begin
          next_state = ST_GATE; // RQ6
        end
      end
      ST_GATE: begin
        if (sel == `IFC_SEL_OFF) begin
          next_state = ST_IDLE; // RQ12
        end else if (gate_sel != `IFC_GATE_OPEN && tb_tick && ticks == gate_ticks(gate_sel) - 4'h1) begin
          next_state = ST_IDLE; // RQ19
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A write restarts or stops, whatever the current state
    if (mode_wr_in) begin
      next_state = (wr_sel != `IFC_SEL_OFF) ? ST_WAIT : ST_IDLE; // RQ4 RQ11
    end
  end

  wire timed_close = (state == ST_GATE) && !mode_wr_in && sel != `IFC_SEL_OFF &&
    gate_sel != `IFC_GATE_OPEN && tb_tick && ticks == gate_ticks(gate_sel) - 4'h1;
  wire opening = (state == ST_WAIT) && (next_state == ST_GATE);

  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      ticks <= 4'h0;
    end else begin
      state <= next_state;
      if (mode_wr_in || opening) begin
        ticks <= 4'h0;
      end else if (state == ST_GATE && tb_tick) begin
        ticks <= ticks + 4'h1; // RQ19
      end
    end
  end

  // ==========================================
  // Counter
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      count <= `IFC_CNT_RST; // RQ16
    end else if (mode_wr_in) begin
      count <= `IFC_CNT_RST; // RQ4
    end else if (opening && in_level) begin
      count <= count + 16'h0001; // RQ7
    end else if (state == ST_GATE && in_rise) begin
      // Natural wrap from ffff to 0000
      count <= count + 16'h0001; // RQ7 RQ13
    end
  end

  // ==========================================
  // Completion flags; set wins over clear
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      gate_complete_flag <= 1'b0; // RQ10
      count_irq_request <= 1'b0;
    end else begin
      if (timed_close) begin
        gate_complete_flag <= 1'b1; // RQ8
      end else if (mode_wr_in) begin
        gate_complete_flag <= 1'b0; // RQ10
      end
      if (timed_close) begin
        count_irq_request <= 1'b1; // RQ8
      end else if (irq_service_in) begin
        count_irq_request <= 1'b0; // RQ9
      end
    end
  end

  assign if_count_mode_out = if_count_mode;
  assign if_count_low_byte_out = count[7:0]; // RQ14
  assign if_count_high_byte_out = count[15:8]; // RQ14
  assign gate_complete_flag_out = gate_complete_flag;
  assign count_irq_request_out = count_irq_request;
  assign gate_open_out = (state == ST_GATE);

endmodule // ifc_counter

/* File: dv/ifc_if_source.sv */
// Square-wave model of one IF input from the tuner front end
`timescale 1ns/1ps
module ifc_if_source #(
  parameter int HALF_NS = 500
) (
  input wire logic en_in,
  output logic sig_out
);
  // ==========
  // Source
  // Held low when disabled so the pin never floats to an unknown
  initial sig_out = 1'b0;
  always #(HALF_NS) sig_out = en_in ? ~sig_out : 1'b0;
endmodule // ifc_if_source

/* File: dv/ifc_counter_chk.sv */
// Port-level assertions for the IF counter
`timescale 1ns/1ps
module ifc_counter_chk (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic am_if_input_in,
  input wire logic fm_if_input_in,
  input wire logic mode_wr_in,
  input wire logic [3:0] mode_wdata_in,
  input wire logic irq_service_in,
  input wire logic [3:0] if_count_mode_out,
  input wire logic [7:0] if_count_low_byte_out,
  input wire logic [7:0] if_count_high_byte_out,
  input wire logic gate_complete_flag_out,
  input wire logic count_irq_request_out,
  input wire logic gate_open_out
);
  wire [15:0] cnt = {if_count_high_byte_out, if_count_low_byte_out};
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========
  // Assertions
  mode_load_a: assert property (mode_wr_in |=> if_count_mode_out == $past(mode_wdata_in))
    else $error("mode register did not load");
  wr_clear_a: assert property (mode_wr_in |=> cnt == 16'h0 && !gate_complete_flag_out)
    else $error("write did not clear count and flag");
  wr_wait_a: assert property (mode_wr_in |=> !gate_open_out)
    else $error("gate opened before a timebase tick");
  off_hold_a: assert property (if_count_mode_out[3:2] == 2'h0 && !mode_wr_in |=> $stable(cnt))
    else $error("count moved while disabled");
  closed_hold_a: assert property (!gate_open_out && !mode_wr_in |=> $stable(cnt) || gate_open_out)
    else $error("count moved with gate closed");
  count_step_a: assert property (!mode_wr_in && if_count_mode_out[3:2] != 2'h3 |=> 16'(cnt - $past(cnt)) <= 16'h1)
    else $error("count stepped by more than one");
  flag_close_a: assert property ($rose(gate_complete_flag_out) |-> $fell(gate_open_out) && count_irq_request_out)
    else $error("flag rose without gate close and request");
  open_noflag_a: assert property ($rose(gate_complete_flag_out) |-> if_count_mode_out[1:0] != 2'h3)
    else $error("open gate raised the flag");
  irq_clear_a: assert property (irq_service_in |=> !count_irq_request_out || $rose(gate_complete_flag_out))
    else $error("request not cleared by service");
  irq_hold_a: assert property (count_irq_request_out && !irq_service_in |=> count_irq_request_out)
    else $error("request dropped without service");
  rst_clear_a: assert property (disable iff (1'b0) sys_rst_in |=> if_count_mode_out == 4'h0 && cnt == 16'h0)
    else $error("reset did not clear mode and count");
  flag_c: cover property ($rose(gate_complete_flag_out));
  service_c: cover property (irq_service_in && count_irq_request_out);
  open_c: cover property (gate_open_out && if_count_mode_out[1:0] == 2'h3);
endmodule // ifc_counter_chk

/* File: dv/testbench.sv */
// Self-checking bench for the IF counter
`timescale 1ns/1ps
module testbench;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic mode_wr_in = 1'b0;
  logic [3:0] mode_wdata_in = 4'h0;
  logic irq_service_in = 1'b0;
  logic src_en = 1'b0;
  wire am_sig, fm_sig, flag, irq, gate;
  wire [3:0] mode;
  wire [7:0] lo, hi;
  int mismatches = 0;
  int n_tests = 0;
  logic [15:0] c1;
  always #5 ref_clk_in = ~ref_clk_in;
  // 1 MHz AM and 10 MHz FM sources
  ifc_if_source #(.HALF_NS(500)) u_am (.en_in(src_en), .sig_out(am_sig));
  ifc_if_source #(.HALF_NS(50)) u_fm (.en_in(src_en), .sig_out(fm_sig));
  // Timebase shortened to 1000 cycles so that a gate fits the run budget
  ifc_counter #(.TB_DIV(1000)) u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .am_if_input_in(am_sig),
    .fm_if_input_in(fm_sig), .mode_wr_in(mode_wr_in), .mode_wdata_in(mode_wdata_in),
    .irq_service_in(irq_service_in), .if_count_mode_out(mode), .if_count_low_byte_out(lo),
    .if_count_high_byte_out(hi), .gate_complete_flag_out(flag), .count_irq_request_out(irq),
    .gate_open_out(gate));
  // ==========
  // Tasks
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task wr(input logic [3:0] d);
    mode_wr_in = 1'b1;
    mode_wdata_in = d;
    @(negedge ref_clk_in);
    mode_wr_in = 1'b0;
    @(negedge ref_clk_in);
  endtask
  // Gate waits up to a full timebase period before opening
  task wait_sig(input bit sel);
    int i;
    for (i = 0; i < 5000 && (sel ? gate : flag) !== 1'b1; i++)
      @(negedge ref_clk_in);
    if (i == 5000) begin
      mismatches++;
      report_and_stop;
    end
  endtask
  // ==========
  // Sequence
  initial begin
    repeat (20) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk({hi, lo}, 16'h0);
    chk({8'h0, mode, flag, irq, gate, 1'b0}, 16'h0);
    src_en = 1'b1;
    wr(4'h4);
    chk({12'h0, mode}, 16'h4);
    wait_sig(1'b1);
    wait_sig(1'b0);
    @(negedge ref_clk_in);
    chk({13'h0, flag, irq, gate}, 16'h6);
    chk({15'h0, ({hi, lo} inside {[16'd10:16'd11]})}, 16'h1);
    irq_service_in = 1'b1;
    @(negedge ref_clk_in);
    irq_service_in = 1'b0;
    @(negedge ref_clk_in);
    chk({15'h0, irq}, 16'h0);
    wr(4'hf);
    chk({15'h0, flag}, 16'h0);
    wait_sig(1'b1);
    repeat (10) @(negedge ref_clk_in);
    c1 = {hi, lo};
    repeat (20000) @(negedge ref_clk_in);
    chk({15'h0, (16'({hi, lo} - c1) inside {[16'd1198:16'd1202]})}, 16'h1);
    chk({14'h0, flag, gate}, 16'h1);
    wr(4'h3);
    repeat (1000) @(negedge ref_clk_in);
    chk({hi, lo}, 16'h0);
    report_and_stop;
  end
endmodule // testbench

bind ifc_counter ifc_counter_chk u_chk (.*);
